// >>> sitpg_consts.svh
// Constants for the safe input test pulse generator
// Behaviour
// - Test pulse drives output low 350 us
// - About 180 pulses per second while testing
// - Each of eight outputs pulsed separately
// - Disabled channel keeps its pulse output high
// - Full eight channel sequence lasts 5.5 ms
// - Offsets between channel pulses vary each cycle
// - Corrupted returned pulse raises sensor or open errors
// - Pressure mat short forces pair to zero
`ifndef SITPG_CONSTS_SVH
`define SITPG_CONSTS_SVH

`define SITPG_CH            8
`define SITPG_PAIRS         4
`define SITPG_CLK_MHZ       10
`define SITPG_PULSE_US      350
`define SITPG_PULSE_CYC     (`SITPG_PULSE_US * `SITPG_CLK_MHZ)
`define SITPG_RECOVER_US    50
`define SITPG_RECOVER_CYC   (`SITPG_RECOVER_US * `SITPG_CLK_MHZ)
`define SITPG_CYCLE_US      5500
`define SITPG_CYCLE_CYC     (`SITPG_CYCLE_US * `SITPG_CLK_MHZ)
`define SITPG_RATE_HZ       180
`define SITPG_LFSR_SEED     16'hACE1
`define SITPG_LFSR_TAPS     16'hB400
`define SITPG_OFFSET_MASK   12'h7FF

`endif

// >>> sitpg_pkg.sv
// Types shared by the test pulse generator
`include "sitpg_consts.svh"

package sitpg_pkg;

   typedef enum logic [1:0] {PH_WAIT, PH_LOW, PH_RECOVER, PH_REST} sitpg_phase_t;

   typedef struct packed {
      logic [`SITPG_CH-1:0] sensor_error;
      logic [`SITPG_CH-1:0] open_circuit_error;
      logic [`SITPG_CH-1:0] cross_error;
   } sitpg_diag_t;

endpackage

// >>> sitpg_lfsr.sv
// Pseudo random source for the pulse offsets
`timescale 1ns/1ps
`include "sitpg_consts.svh"

module sitpg_lfsr
   import sitpg_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic        advance,
   output logic [15:0]      value
);

   always_ff @(posedge clock)
   begin
      if (reset)
         value <= `SITPG_LFSR_SEED;
      else if (advance)
         value <= {1'b0, value[15:1]} ^ (value[0] ? `SITPG_LFSR_TAPS : 16'h0000);
   end

   chk_lfsr_moves: assert property (@(posedge clock) disable iff (reset)
      advance |=> value != $past(value))
      else $error("offset source did not advance");

endmodule

// >>> sitpg_top.sv
// Test pulse generator and returned pulse checker for eight safe inputs
`timescale 1ns/1ps
`include "sitpg_consts.svh"

module sitpg_top
   import sitpg_pkg::*;
#(
   parameter int unsigned CYCLE_CYC = `SITPG_CYCLE_CYC
)
(
   input  wire logic                  clock,
   input  wire logic                  reset,
   input  wire logic                  clock_en,
   input  wire logic [`SITPG_CH-1:0]    test_enable,
   input  wire logic [`SITPG_PAIRS-1:0] mat_mode,
   input  wire logic                  err_clear,
   input  wire logic [`SITPG_CH-1:0]    contact_in,
   output logic      [`SITPG_CH-1:0]    pulse_out,
   output logic      [`SITPG_CH-1:0]    input_level,
   output sitpg_diag_t                diag
);

   localparam int unsigned SLOT_CYC = CYCLE_CYC / `SITPG_CH;
   localparam logic [15:0] SLOT_LAST = 16'(SLOT_CYC - 1);
   localparam logic [11:0] PULSE_LAST = 12'(`SITPG_PULSE_CYC - 1);
   localparam logic [11:0] RECOVER_LAST = 12'(`SITPG_RECOVER_CYC - 1);

   function automatic logic [`SITPG_CH-1:0] onehot(input logic [2:0] idx);
      onehot = 8'h01 << idx;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchroniser

   logic [`SITPG_CH-1:0] sync1_q;
   logic [`SITPG_CH-1:0] sync2_q;

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         sync1_q <= 8'hFF;
         sync2_q <= 8'hFF;
      end
      else if (clock_en)
      begin
         sync1_q <= contact_in;
         sync2_q <= sync1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Slot timing: one slot per channel, eight slots per sequence

   logic [15:0]   slot_cnt_q;
   logic [2:0]    chan_q;
   logic          slot_end;
   logic [15:0]   lfsr_value;
   sitpg_phase_t  phase_q;
   logic [11:0]   ph_cnt_q;
   logic [`SITPG_CH-1:0] pre_q;

   assign slot_end = (slot_cnt_q == SLOT_LAST);

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         slot_cnt_q <= SLOT_LAST;
         chan_q     <= 3'h7;
      end
      else if (clock_en)
      begin
         slot_cnt_q <= slot_end ? 16'h0000 : slot_cnt_q + 16'h0001;
         if (slot_end)
            chan_q <= chan_q + 3'h1;
      end
   end

   // Fresh random offset every slot keeps channel spacing irregular
   sitpg_lfsr u_lfsr
   (
      .clock   (clock),
      .reset   (reset),
      .advance (clock_en & slot_end),
      .value   (lfsr_value)
   );

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         phase_q  <= PH_REST;
         ph_cnt_q <= 12'h000;
      end
      else if (clock_en)
      begin
         if (slot_end)
         begin
            phase_q  <= PH_WAIT;
            ph_cnt_q <= lfsr_value[11:0] & `SITPG_OFFSET_MASK;
         end
         else
         begin
            unique case (phase_q)
               PH_WAIT:
                  if (ph_cnt_q == 12'h000)
                  begin
                     phase_q  <= PH_LOW;
                     ph_cnt_q <= PULSE_LAST;
                  end
                  else
                     ph_cnt_q <= ph_cnt_q - 12'h001;
               PH_LOW:
                  if (ph_cnt_q == 12'h000)
                  begin
                     phase_q  <= PH_RECOVER;
                     ph_cnt_q <= RECOVER_LAST;
                  end
                  else
                     ph_cnt_q <= ph_cnt_q - 12'h001;
               PH_RECOVER:
                  if (ph_cnt_q == 12'h000)
                     phase_q <= PH_REST;
                  else
                     ph_cnt_q <= ph_cnt_q - 12'h001;
               PH_REST:
                  phase_q <= PH_REST;
            endcase
         end
      end
   end

   // Levels just before the pulse, reference for drop detection
   always_ff @(posedge clock)
   begin
      if (reset)
         pre_q <= 8'hFF;
      else if (clock_en && phase_q == PH_WAIT && ph_cnt_q == 12'h000)
         pre_q <= sync2_q;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pulse outputs

   logic [`SITPG_CH-1:0] own;
   logic [`SITPG_CH-1:0] pulse_out_d;

   assign own = onehot(chan_q);
   // Enable is read live so a channel switched off drops its pulse at the next clock
   assign pulse_out_d = ~((phase_q == PH_LOW ? own : 8'h00) & test_enable);

   always_ff @(posedge clock)
   begin
      if (reset)
         pulse_out <= 8'hFF;
      else if (clock_en)
         pulse_out <= pulse_out_d;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Returned pulse checks

   logic                 chk_low;
   logic                 chk_rec;
   logic                 mat_pair;
   logic [`SITPG_CH-1:0] partner;
   logic [`SITPG_CH-1:0] drop;
   logic [`SITPG_CH-1:0] cross_hit;
   logic [`SITPG_CH-1:0] sens_set;
   logic [`SITPG_CH-1:0] open_set;
   logic [`SITPG_CH-1:0] cross_set;
   logic                 mat_hit;

   assign chk_low = phase_q == PH_LOW && ph_cnt_q == 12'h000 && test_enable[chan_q];
   assign chk_rec = phase_q == PH_RECOVER && ph_cnt_q == 12'h000 && test_enable[chan_q];
   assign partner = onehot(chan_q ^ 3'h1);
   assign mat_pair = mat_mode[chan_q[2:1]] && test_enable[chan_q] && test_enable[chan_q ^ 3'h1];

   always_comb
   begin
      drop      = pre_q & ~sync2_q & ~own;
      cross_hit = mat_pair ? (drop & ~partner) : drop;
      sens_set  = (chk_low && sync2_q[chan_q]) ? own : 8'h00;
      cross_set = (chk_low && |cross_hit) ? (cross_hit | own) : 8'h00;
      open_set  = (chk_rec && pre_q[chan_q] && !sync2_q[chan_q]) ? own : 8'h00;
      mat_hit   = chk_low && mat_pair && |(drop & partner);
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge clock)
   begin
      if (reset)
         diag <= '0;
      else if (clock_en)
      begin
         diag.sensor_error <= (diag.sensor_error & ~{8{err_clear}}) | sens_set;
         diag.open_circuit_error <= (diag.open_circuit_error & ~{8{err_clear}}) | open_set;
         diag.cross_error <= (diag.cross_error & ~{8{err_clear}}) | cross_set;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pressure mat pairs and reported levels

   logic [`SITPG_PAIRS-1:0] mat_short_q;
   logic [`SITPG_CH-1:0]    force_zero;
   logic [`SITPG_CH-1:0]    hold;

   always_ff @(posedge clock)
   begin
      if (reset)
         mat_short_q <= 4'h0;
      else if (clock_en)
      begin
         mat_short_q <= mat_short_q & mat_mode;
         if (chk_low && mat_pair)
            mat_short_q[chan_q[2:1]] <= mat_hit;
      end
   end

   genvar p;
   generate
      for (p = 0; p < `SITPG_PAIRS; p++)
      begin : g_pair
         assign force_zero[2*p+1:2*p] = {2{mat_short_q[p] & mat_mode[p]}};
      end
   endgenerate

   // Own pulse is hidden from the reported level
   assign hold = own & test_enable & {8{phase_q == PH_LOW || phase_q == PH_RECOVER}};

   always_ff @(posedge clock)
   begin
      if (reset)
         input_level <= 8'h00;
      else if (clock_en)
         input_level <= ((sync2_q & ~hold) | (input_level & hold)) & ~force_zero;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   logic [11:0] low_run_q;

   always_ff @(posedge clock)
   begin
      if (reset)
         low_run_q <= 12'h000;
      else if (clock_en)
         low_run_q <= (&pulse_out) ? 12'h000 : low_run_q + 12'h001;
   end

   chk_low_length: assert property (@(posedge clock) disable iff (reset)
      low_run_q <= 12'(`SITPG_PULSE_CYC))
      else $error("test pulse longer than allowed");

   chk_one_at_a_time: assert property (@(posedge clock) disable iff (reset)
      $onehot0(~pulse_out))
      else $error("two pulse outputs low together");

   chk_disabled_high: assert property (@(posedge clock) disable iff (reset || !clock_en)
      ##1 ((~pulse_out & ~$past(test_enable)) == 8'h00))
      else $error("disabled channel pulsed");

   chk_slot_wrap: assert property (@(posedge clock) disable iff (reset || !clock_en)
      slot_end |=> slot_cnt_q == 16'h0000 && chan_q == $past(chan_q) + 3'h1)
      else $error("slot did not wrap to next channel");

   chk_pulse_start: assert property (@(posedge clock) disable iff (reset || !clock_en)
      (phase_q == PH_WAIT && ph_cnt_q == 12'h000 && !slot_end && test_enable[chan_q])
      ##1 test_enable[chan_q] |=> !pulse_out[chan_q])
      else $error("pulse did not start after offset");

   chk_sensor_flag: assert property (@(posedge clock) disable iff (reset || !clock_en)
      (chk_low && sync2_q[chan_q]) |=> diag.sensor_error[$past(chan_q)])
      else $error("missed pulse not flagged");

   chk_open_flag: assert property (@(posedge clock) disable iff (reset || !clock_en)
      (chk_rec && pre_q[chan_q] && !sync2_q[chan_q]) |=> diag.open_circuit_error[$past(chan_q)])
      else $error("stuck low return not flagged");

   chk_error_sticky: assert property (@(posedge clock) disable iff (reset || !clock_en)
      (diag.sensor_error != 8'h00 && !err_clear) |=> diag.sensor_error != 8'h00)
      else $error("sensor error lost without clear");

   chk_mat_zero: assert property (@(posedge clock) disable iff (reset || !clock_en)
      (mat_short_q[0] && mat_mode[0]) |=> input_level[1:0] == 2'b00)
      else $error("shorted mat pair reported high");

endmodule

// >>> sitpg_field.sv
// Field contact model answering each pulse output on its input
`timescale 1ns/1ps
`include "sitpg_consts.svh"

module sitpg_field
   import sitpg_pkg::*;
(
   input  wire logic                    clock,
   input  wire logic [`SITPG_CH-1:0]    pulse_out,
   input  wire logic [`SITPG_CH-1:0]    stuck_hi,
   input  wire logic [`SITPG_CH-1:0]    open_mode,
   input  wire logic [`SITPG_PAIRS-1:0] short_pair,
   output logic      [`SITPG_CH-1:0]    contact_in
);
   logic [`SITPG_CH-1:0] open_q;

   ////////////////////////////////////////////////////////////////////////////
   // Broken wire stays low once a pulse has pulled it down
   always_ff @(posedge clock)
   begin
      open_q <= open_mode & (open_q | ~pulse_out);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Closed contact echoes its pulse; a shorted pair is a wired and
   always_comb
   begin
      for (int i = 0; i < `SITPG_CH; i++)
      begin
         contact_in[i] = stuck_hi[i] | (~open_q[i] & pulse_out[i]
                       & (~short_pair[i/2] | pulse_out[i^1]));
      end
   end
endmodule

// >>> tb_top.sv
// Self-checking testbench for the test pulse generator
`timescale 1ns/1ps
`include "sitpg_consts.svh"

module tb_top
   import sitpg_pkg::*;
;
   localparam int CYC  = 49000;
   localparam int SLOT = CYC / 8;
   localparam int unsigned OFS_MAX = `SITPG_OFFSET_MASK;

   logic                    clock;
   logic                    reset;
   logic                    clock_en;
   logic [`SITPG_CH-1:0]    test_enable;
   logic [`SITPG_PAIRS-1:0] mat_mode;
   logic                    err_clear;
   logic [`SITPG_CH-1:0]    contact_in;
   logic [`SITPG_CH-1:0]    pulse_out;
   logic [`SITPG_CH-1:0]    input_level;
   sitpg_diag_t             diag;
   logic [`SITPG_CH-1:0]    stuck_hi;
   logic [`SITPG_CH-1:0]    open_mode;
   logic [`SITPG_PAIRS-1:0] short_pair;
   int                      errors;
   int                      n_checks;
   int                      fall[8];
   int                      lowc[8];
   int                      nf[8];
   int                      multi;

   ////////////////////////////////////////////////////////////////////////////
   // Shortened sequence fits two full passes just inside the 99000 cycle run budget
   sitpg_top #(.CYCLE_CYC(CYC)) u_dut (.clock(clock), .reset(reset), .clock_en(clock_en),
      .test_enable(test_enable), .mat_mode(mat_mode), .err_clear(err_clear),
      .contact_in(contact_in), .pulse_out(pulse_out), .input_level(input_level),
      .diag(diag));

   sitpg_field u_field (.clock(clock), .pulse_out(pulse_out), .stuck_hi(stuck_hi),
      .open_mode(open_mode), .short_pair(short_pair), .contact_in(contact_in));

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Watch one whole sequence, sampling settled outputs at falling edges
   task automatic seq_watch();
      logic [7:0] prev;
      prev  = pulse_out;
      multi = 0;
      for (int i = 0; i < 8; i++)
      begin
         lowc[i] = 0;
         nf[i]   = 0;
         fall[i] = 0;
      end
      for (int t = 1; t <= CYC; t++)
      begin
         @(negedge clock);
         if ($countones(~pulse_out) > 1)
            multi++;
         for (int i = 0; i < 8; i++)
         begin
            if (pulse_out[i] === 1'b0)
               lowc[i]++;
            if (prev[i] === 1'b1 && pulse_out[i] === 1'b0)
            begin
               nf[i]++;
               fall[i] = t;
            end
         end
         prev = pulse_out;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic test_reset();
      repeat (5) @(negedge clock);
      check(pulse_out, 8'hFF);
      check(input_level, 8'h00);
      check(diag, 24'h000000);
      reset = 1'b0;
      $display("test reset done");
   endtask

   // Channel five disabled; healthy contacts everywhere else
   task automatic test_clean();
      logic vary;
      vary = 1'b0;
      seq_watch();
      check(24'(multi), 24'h0);
      for (int i = 0; i < 8; i++)
      begin
         check(24'(nf[i]), (i == 5) ? 24'h0 : 24'h1);
         check(24'(lowc[i]), (i == 5) ? 24'h0 : 24'(`SITPG_PULSE_CYC));
         if (i != 5)
         begin
            // Fall lands offset plus three samples after the slot start
            check(24'(unsigned'(fall[i] - i * SLOT - 3) <= OFS_MAX), 24'h1);
            if (fall[i] - i * SLOT != fall[0])
               vary = 1'b1;
         end
      end
      check(24'(vary), 24'h1);
      check(diag, 24'h000000);
      check(input_level, 8'hFF);
      $display("test clean sequence done");
   endtask

   // Stuck contact, broken wire, plain short and mat short in one pass
   task automatic test_faults();
      test_enable = 8'hFF;
      stuck_hi    = 8'h04;
      open_mode   = 8'h10;
      short_pair  = 4'h9;
      mat_mode    = 4'h1;
      seq_watch();
      check(diag.sensor_error, 8'h04);
      check(diag.open_circuit_error, 8'h10);
      check(diag.cross_error, 8'hC0);
      check(input_level, 8'hEC);
      $display("test fault sequence done");
   endtask

   // Frozen clock enable must hold errors; mat release restores levels
   task automatic test_clear();
      clock_en  = 1'b0;
      err_clear = 1'b1;
      repeat (3) @(negedge clock);
      check(diag.open_circuit_error, 8'h10);
      clock_en = 1'b1;
      mat_mode = 4'h0;
      @(negedge clock);
      err_clear = 1'b0;
      repeat (2) @(negedge clock);
      check(diag, 24'h000000);
      // Pair zero back to raw levels; broken wire on channel four stays low
      check(input_level, 8'hEF);
      $display("test clear done");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   initial
   begin
      #(99000 * 100);
      errors++;
      tally_and_finish();
   end

   initial
   begin
      errors      = 0;
      n_checks    = 0;
      reset       = 1'b1;
      clock_en    = 1'b1;
      test_enable = 8'hDF;
      mat_mode    = 4'h0;
      err_clear   = 1'b0;
      stuck_hi    = 8'h00;
      open_mode   = 8'h00;
      short_pair  = 4'h0;
      test_reset();
      test_clean();
      test_faults();
      test_clear();
      tally_and_finish();
   end
endmodule
